// >>> rtl/flash_seq_params.svh
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// register byte offsets
`define CTRL_OFFSET 4'h0
`define KEY_OFFSET 4'h4
`define STATUS_OFFSET 4'h8

// control field positions
`define OP_LSB 0
`define OP_MSB 5
`define ERASE_BIT 6
`define PERMIT_BIT 14
`define START_BIT 15
`define CTRL_RESET 16'h0000

// operation codes and keys
`define OP_ROW_ERASE 6'h18
`define OP_ROW_PROG 6'h04
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa

// row geometry
`define ROW_WORDS 32

// cycle times in microseconds, clock in MHz
`define CLK_MHZ 20
`define ERASE_TIME_US 2000
`define PROG_TIME_US 2000

`endif

// >>> rtl/flash_seq_pkg.sv
package flash_seq_pkg;
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_GOT_FIRST = 2'b01,
        KEY_ARMED = 2'b10
    } key_state_e;
endpackage

// >>> rtl/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer #(
    parameter int WIDTH = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] cnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= count;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign busy = (cnt_reg != '0);
    assign done = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule

// >>> rtl/flash_row_erase_program_sequencer.sv
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_row_erase_program_sequencer
    import flash_seq_pkg::*;
#(
    parameter int ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ,
    parameter int PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic cpu_stall,
    output logic flash_erase_row,
    output logic flash_program_row,
    output logic [4:0] flash_row_word_count
);
    localparam int TW = 20;

    // ----------------------------------------------------------------
    // write channel capture
    // ----------------------------------------------------------------
    logic aw_held_reg, w_held_reg;
    logic [3:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    logic ctrl_hit, key_hit, known_addr;
    assign ctrl_hit = (awaddr_reg[3:2] == 2'(`CTRL_OFFSET >> 2));
    assign key_hit = (awaddr_reg[3:2] == 2'(`KEY_OFFSET >> 2));
    assign known_addr = ctrl_hit || key_hit
        || (awaddr_reg[3:2] == 2'(`STATUS_OFFSET >> 2));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known_addr ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // unlock sequence
    // ----------------------------------------------------------------
    key_state_e key_reg;
    logic key_lo_wr;
    assign key_lo_wr = wr_fire && key_hit && wstrb_reg[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_reg <= KEY_IDLE;
        end else if (wr_fire) begin
            case (key_reg)
                KEY_IDLE: begin
                    if (key_lo_wr && wdata_reg[7:0] == `KEY_FIRST) begin
                        key_reg <= KEY_GOT_FIRST;
                    end
                end
                KEY_GOT_FIRST: begin
                    if (key_lo_wr && wdata_reg[7:0] == `KEY_SECOND) begin
                        key_reg <= KEY_ARMED;
                    end else if (key_lo_wr
                            && wdata_reg[7:0] == `KEY_FIRST) begin
                        key_reg <= KEY_GOT_FIRST;
                    end else begin
                        key_reg <= KEY_IDLE;
                    end
                end
                // the very next write uses or spends the unlock
                KEY_ARMED: key_reg <= KEY_IDLE;
                default: key_reg <= KEY_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // control register and cycle launch
    // ----------------------------------------------------------------
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_wr_val;
    logic start_req, is_erase, is_prog, launch, done;
    logic busy;
    logic [TW-1:0] load_count;

    always_comb begin
        ctrl_wr_val = ctrl_reg;
        if (wstrb_reg[0]) begin
            ctrl_wr_val[7:0] = wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
            ctrl_wr_val[15:8] = wdata_reg[15:8];
        end
    end

    assign is_erase = ctrl_wr_val[`OP_MSB:`OP_LSB] == `OP_ROW_ERASE
        && ctrl_wr_val[`ERASE_BIT] && ctrl_wr_val[`PERMIT_BIT];
    assign is_prog = ctrl_wr_val[`OP_MSB:`OP_LSB] == `OP_ROW_PROG
        && !ctrl_wr_val[`ERASE_BIT] && ctrl_wr_val[`PERMIT_BIT];
    assign start_req = wr_fire && ctrl_hit && ctrl_wr_val[`START_BIT]
        && !ctrl_reg[`START_BIT];
    assign launch = start_req && key_reg == KEY_ARMED
        && (is_erase || is_prog);
    assign load_count = is_erase ? TW'(ERASE_CYCLES) : TW'(PROG_CYCLES);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (done) begin
            ctrl_reg[`START_BIT] <= 1'b0;
        end else if (wr_fire && ctrl_hit && !busy) begin
            ctrl_reg[14:0] <= ctrl_wr_val[14:0];
            ctrl_reg[`START_BIT] <= launch;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_erase_row <= 1'b0;
            flash_program_row <= 1'b0;
        end else if (launch && !busy) begin
            flash_erase_row <= is_erase;
            flash_program_row <= is_prog;
        end else if (done) begin
            flash_erase_row <= 1'b0;
            flash_program_row <= 1'b0;
        end
    end

    cycle_timer #(.WIDTH(TW)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .load(launch && !busy),
        .count(load_count),
        .busy(busy),
        .done(done)
    );

    assign cpu_stall = busy;
    // row width exposed so the array knows it handles one whole row
    assign flash_row_word_count = 5'(`ROW_WORDS - 1);

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr[3:2])
                2'(`CTRL_OFFSET >> 2): s_axi_rdata <= {16'h0, ctrl_reg};
                // key register reads back as zero to hide the sequence
                2'(`KEY_OFFSET >> 2): s_axi_rdata <= 32'h0;
                2'(`STATUS_OFFSET >> 2): s_axi_rdata <= {28'h0,
                    flash_program_row, flash_erase_row, key_reg};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> sim/flash_array_model.sv
`timescale 1ns/1ps
// ----
// flash array stand-in
// ----
module flash_array_model (
    input wire logic erase,
    input wire logic prog,
    input wire logic [4:0] word_count,
    output int n_erase = 0,
    output int n_prog = 0
);
    // only a request for the whole 32-word row counts as a row operation
    always @(posedge erase) begin
        if (word_count == 5'h1f) n_erase++;
    end
    always @(posedge prog) begin
        if (word_count == 5'h1f) n_prog++;
    end
endmodule

// >>> sim/flash_seq_monitor.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module flash_seq_monitor #(
    parameter int ERASE_CYCLES = 10,
    parameter int PROG_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic cpu_stall,
    input wire logic flash_erase_row,
    input wire logic flash_program_row,
    input wire logic [4:0] flash_row_word_count
);
    int run_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // stall length counter, so cycle times are checked to the exact figure
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) run_reg <= 0;
        else run_reg <= cpu_stall ? run_reg + 1 : 0;
    end
    property p_row; flash_row_word_count == 5'h1f; endproperty
    a_row: assert property (p_row) else $error("row size");
    property p_one; !(flash_erase_row && flash_program_row); endproperty
    a_one: assert property (p_one) else $error("two ops");
    property p_stall; cpu_stall == (flash_erase_row || flash_program_row);
    endproperty
    a_stall: assert property (p_stall) else $error("stall");
    property p_elen; $fell(flash_erase_row) |-> run_reg == ERASE_CYCLES;
    endproperty
    a_elen: assert property (p_elen) else $error("erase len");
    property p_plen; $fell(flash_program_row) |-> run_reg == PROG_CYCLES;
    endproperty
    a_plen: assert property (p_plen) else $error("prog time");
    property p_clr; $fell(cpu_stall) |-> !cpu_stall [*3]; endproperty
    a_clr: assert property (p_clr) else $error("restart");
    property p_bw; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_bw: assert property (p_bw) else $error("write ready");
    property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar: assert property (p_ar) else $error("read ready");
endmodule
bind flash_row_erase_program_sequencer flash_seq_monitor #(
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)
) u_mon (.clk, .rst_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arready, .s_axi_rvalid, .cpu_stall, .flash_erase_row,
    .flash_program_row, .flash_row_word_count);

// >>> sim/tb.sv
`timescale 1ns/1ps
// ----
// sequencer bench
// ----
module tb;
    localparam int CYC = 10;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [3:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, ctrl_m = 0;
    logic [7:0] lf = 8'h43;
    wire awr, wrd, bv, arr, rv, stall, er, pr;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [4:0] wc;
    int n_errors = 0, cmp_count = 0, cyc = 0, stall_n = 0, tot = 0;
    int n_er = 0, n_pr = 0, kst = 0, ne, np, busy_m = 0;
    always #25 clk = ~clk;
    always @(negedge clk) if (stall === 1'b1) stall_n++;
    flash_row_erase_program_sequencer #(.ERASE_CYCLES(CYC), .PROG_CYCLES(CYC))
    dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .cpu_stall(stall), .flash_erase_row(er), .flash_program_row(pr),
        .flash_row_word_count(wc));
    flash_array_model far (.erase(er), .prog(pr), .word_count(wc),
        .n_erase(ne), .n_prog(np));
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end
    // bit 1 forced so a random key byte never equals the first key
    function automatic logic [7:0] nx();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf | 8'h02;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask
    // d is write data, or the expected read data
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        logic ha, hw, hb;
        logic [1:0] r;
        logic [31:0] q;
        @(posedge clk);
        if (w) begin
            awa <= a;
            wd <= d;
            awv <= 1;
            wv <= 1;
            bre <= 1;
        end else begin
            ara <= a;
            arv <= 1;
            rre <= 1;
        end
        do begin
            @(negedge clk);
            ha = w ? awv && awr : arv && arr;
            hw = wv && wrd;
            hb = w ? bv : rv;
            r = w ? br : rr;
            q = rdat;
            @(posedge clk);
            if (ha && w) awv <= 0;
            if (ha && !w) arv <= 0;
            if (hw) wv <= 0;
        end while (!hb);
        bre <= 0;
        rre <= 0;
        chk(r, a > 4'h8 ? 2'b10 : 2'b00);
        if (!w && a <= 4'h8) chk(q, d);
        // control writes while a cycle runs leave the register alone
        if (w && a == 0 && !busy_m) ctrl_m = d & 32'h407f;
        if (w && a == 0 && d[15] && kst == 2 && d[14] && !busy_m
            && d[5:0] == (d[6] ? 6'h18 : 6'h04)) begin
            n_er += d[6];
            n_pr += !d[6];
            tot += CYC;
            busy_m = 1;
        end
        if (w) kst = a != 4 ? 0 : d[7:0] == 8'h55 ? 1 :
            (d[7:0] == 8'haa && kst == 1) ? 2 : 0;
    endtask
    task automatic op(input logic [31:0] s, k1, input logic [3:0] a2,
        input logic [31:0] d2, st);
        bus(1, 4'h0, s);
        bus(1, 4'h4, k1);
        bus(0, 4'h8, kst);
        bus(1, a2, d2);
        bus(1, 4'h0, st);
        // start bit must read back set while the cycle runs
        bus(0, 4'h0, ctrl_m | busy_m << 15);
        // dropped during a stall, otherwise it clears the register
        bus(1, 4'h0, 32'h0);
        repeat (40) @(posedge clk);
        busy_m = 0;
        chk(stall_n, tot);
        bus(0, 4'h0, ctrl_m);
        chk(ne, n_er);
        chk(np, n_pr);
    endtask
    task automatic close_out();
        if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        bus(0, 4'h0, 0);
        // key register reads back as zero
        bus(0, 4'h4, 0);
        bus(0, 4'hc, 0);
        op(32'h4058, 8'h55, 4'h4, 8'haa, 32'hc058);
        op(32'h4004, 8'h55, 4'h4, 8'haa, 32'hc004);
        op(32'h4058, 8'haa, 4'h4, 8'h55, 32'hc058);
        op(32'h4004, 8'h55, 4'h0, 32'h4004, 32'hc004);
        op(32'h4058, 8'h55, 4'hc, nx(), 32'hc058);
        op(32'h4058, nx(), 4'h4, 8'haa, 32'hc058);
        op(32'h0058, 8'h55, 4'h4, 8'haa, 32'h8058);
        op(32'h4044, 8'h55, 4'h4, 8'haa, 32'hc044);
        close_out();
    end
endmodule
